//--- core/wiper_host.v
`timescale 1ns/100ps
`include "wiper_host_consts.vh"

// How it works
// - select rise with step low skips store
// - selects held high from reset
// - direction changes only with step high
// - select falls only while step high
// - select held high deselect time after store
module wiper_host #(
   parameter DESEL_STORE_CYC = `DESEL_STORE_CYC
) (
   // clock and reset
   input  wire        mclk,
   input  wire        rst,
   // command port, one per channel
   input  wire [1:0]  cmd_valid,
   output wire [1:0]  cmd_ready,
   input  wire [1:0]  cmd_dir,
   input  wire [9:0]  cmd_steps,
   input  wire [1:0]  cmd_store,
   // host's tracked position per channel
   output wire [9:0]  pos,
   // device pins
   output wire [1:0]  sel_n,
   output wire [1:0]  step_n,
   output wire [1:0]  dir
);

   // =====================================================
   // states
   localparam [6:0] S_IDLE  = 7'h01;
   localparam [6:0] S_SETUP = 7'h02;
   localparam [6:0] S_LOW   = 7'h04;
   localparam [6:0] S_HIGH  = 7'h08;
   localparam [6:0] S_PRE   = 7'h10;
   localparam [6:0] S_EXIT  = 7'h20;
   localparam [6:0] S_WAIT  = 7'h40;

   // longest wait, the store hold, still fits 24 bits
   function [23:0] cyc;
      input integer n;
      begin
         cyc = n[23:0];
      end
   endfunction

   // saturating step, mirrors the device counter
   function [4:0] step_pos;
      input [4:0] p;
      input       up;
      begin
         if (up)
            step_pos = (p == `POS_MAX) ? p : p + 5'h01;
         else
            step_pos = (p == 5'h00) ? p : p - 5'h01;
      end
   endfunction

   // a countdown ends on the cycle its timer reads one or less
   function expired;
      input [23:0] t;
      begin
         expired = (t <= 24'h000001);
      end
   endfunction

   // =====================================================
   // one engine per channel, no shared state
   genvar c;
   generate
      for (c = 0; c < 2; c = c + 1) begin : ch
         // pin drivers, countdown and tracked place
         reg [6:0]  state;
         reg [23:0] timer;
         reg [4:0]  left;
         reg        store;
         reg        sel_pin;
         reg        step_pin;
         reg        dir_pin;
         reg [4:0]  place;
         // next values, settled by the sequencing block below
         reg [6:0]  next_state;
         reg [23:0] next_timer;
         reg [4:0]  next_left;
         reg        next_store;
         reg        next_sel_pin;
         reg        next_step_pin;
         reg        next_dir_pin;
         reg [4:0]  next_place;

         // ready only between whole sequences, one command per channel
         assign cmd_ready[c] = (state == S_IDLE);
         assign sel_n[c]     = sel_pin;
         assign step_n[c]    = step_pin;
         assign dir[c]       = dir_pin;
         assign pos[c*5+:5]  = place;

         // =====================================================
         // sequencing
         always @* begin
            next_state    = state;
            next_timer    = timer;
            next_left     = left;
            next_store    = store;
            next_sel_pin  = sel_pin;
            next_step_pin = step_pin;
            next_dir_pin  = dir_pin;
            next_place    = place;
            case (state)
               S_IDLE: begin
                  if (cmd_valid[c]) begin
                     if (cmd_steps[c*5+:5] == 5'h00 && !cmd_store[c]) begin
                        // nothing to move or keep: selecting would only risk a stray step
                        next_timer = cyc(`DESEL_NOSTORE_CYC);
                        next_state = S_WAIT;
                     end else begin
                        next_dir_pin = cmd_dir[c];  // step high here
                        next_left    = cmd_steps[c*5+:5];
                        next_store   = cmd_store[c];
                        next_sel_pin = 1'b0;
                        next_timer   = cyc(`CS_SETUP_CYC > `DIR_SETUP_CYC ? `CS_SETUP_CYC : `DIR_SETUP_CYC);
                        next_state   = S_SETUP;
                     end
                  end
               end
               S_SETUP, S_HIGH: begin
                  if (!expired(timer)) begin
                     next_timer = timer - 24'h000001;
                  end else if (left != 5'h00) begin
                     next_step_pin = 1'b0;
                     next_place    = step_pos(place, dir_pin);
                     next_left     = left - 5'h01;
                     next_timer    = cyc(`STEP_LOW_CYC);
                     next_state    = S_LOW;
                  end else begin
                     next_timer = cyc(`STEP_TO_DESEL_CYC);
                     next_state = S_PRE;
                  end
               end
               S_LOW: begin
                  if (!expired(timer)) begin
                     next_timer = timer - 24'h000001;
                  end else if (left == 5'h00 && !store) begin
                     // last step of a move not kept: strobe stays low, no extra falling edge
                     next_timer = cyc(`STEP_TO_DESEL_CYC);
                     next_state = S_PRE;
                  end else begin
                     next_step_pin = 1'b1;
                     next_timer    = cyc(`STEP_HIGH_CYC);
                     next_state    = S_HIGH;
                  end
               end
               S_PRE: begin
                  // strobe is frozen here so the select rise sees one clean level
                  if (!expired(timer)) begin
                     next_timer = timer - 24'h000001;
                  end else begin
                     next_sel_pin = 1'b1;
                     next_state   = S_EXIT;
                  end
               end
               S_EXIT: begin
                  next_step_pin = 1'b1;             // strobe returns high only after select
                  if (store)
                     next_timer = cyc(DESEL_STORE_CYC);
                  else
                     next_timer = cyc(`DESEL_NOSTORE_CYC);
                  next_state = S_WAIT;
               end
               S_WAIT: begin
                  if (!expired(timer))
                     next_timer = timer - 24'h000001;
                  else
                     next_state = S_IDLE;
               end
               default: begin
                  next_sel_pin  = 1'b1;
                  next_step_pin = 1'b1;
                  next_state    = S_WAIT;
               end
            endcase
         end

         // =====================================================
         // registers
         always @(posedge mclk or posedge rst) begin
            // selects high and strobe idle through reset, so nothing is stored by accident
            if (rst) begin
               state    <= S_WAIT;
               timer    <= 24'h000000;
               left     <= 5'h00;
               store    <= 1'b0;
               sel_pin  <= 1'b1;
               step_pin <= 1'b1;
               dir_pin  <= 1'b0;
               place    <= `POS_RESET;  // host cannot know the recalled value
            end else begin
               state    <= next_state;
               timer    <= next_timer;
               left     <= next_left;
               store    <= next_store;
               sel_pin  <= next_sel_pin;
               step_pin <= next_step_pin;
               dir_pin  <= next_dir_pin;
               place    <= next_place;
            end
         end
      end
   endgenerate

endmodule // wiper_host

//--- core/wiper_host_consts.vh
`ifndef WIPER_HOST_CONSTS_VH
`define WIPER_HOST_CONSTS_VH
// =====================================================
// timing in nanoseconds, store hold in milliseconds, and cycle counts at 10 MHz
`define CLK_PERIOD_NS        100
`define CS_SETUP_NS          100
`define DIR_SETUP_NS         100
`define STEP_LOW_NS          1000
`define STEP_HIGH_NS         1000
`define STEP_TO_DESEL_NS     1000
`define DESEL_NOSTORE_NS     250
`define DESEL_STORE_MS       10
`define CEIL_CYC(ns)         (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CS_SETUP_CYC         `CEIL_CYC(`CS_SETUP_NS)
`define DIR_SETUP_CYC        `CEIL_CYC(`DIR_SETUP_NS)
`define STEP_LOW_CYC         `CEIL_CYC(`STEP_LOW_NS)
`define STEP_HIGH_CYC        `CEIL_CYC(`STEP_HIGH_NS)
`define STEP_TO_DESEL_CYC    `CEIL_CYC(`STEP_TO_DESEL_NS)
`define DESEL_NOSTORE_CYC    `CEIL_CYC(`DESEL_NOSTORE_NS)
`define DESEL_STORE_CYC      `CEIL_CYC(`DESEL_STORE_MS * 1000000)
// =====================================================
// position range
`define POS_MAX              5'h1F
`define POS_RESET            5'h00
`endif

//--- test/test_wiper_host.sv
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; $display("CHECK FAILED %0t value", $time); end end
module test_wiper_host;
   logic mclk = 0, rst = 1;
   logic [1:0] cmd_valid = 0, cmd_dir = 0, cmd_store = 0;
   logic [9:0] cmd_steps = 0;
   wire [1:0] cmd_ready, sel_n, step_n, dir;
   wire [9:0] pos, cnt, nv;
   logic [4:0] ex[2] = '{5'h05, 5'h05}, hp[2] = '{5'h00, 5'h00}, sv[2] = '{5'h05, 5'h05};
   int num_errors = 0, total_checks = 0, cyc = 0;
   wiper_host #(.DESEL_STORE_CYC(20)) u_wiper_host (.mclk, .rst, .cmd_valid, .cmd_ready, .cmd_dir, .cmd_steps,
      .cmd_store, .pos, .sel_n, .step_n, .dir);
   wiper_dev u_wiper_dev (.sel_n, .step_n, .dir, .cnt, .nv);
   initial forever #50 mclk = ~mclk;
   always @(posedge mclk) if (++cyc == 20000) begin
      num_errors++;
      complete_run();
   end
   function automatic [4:0] mv(input [4:0] v, input d, input [4:0] n);
      repeat (n) v = d ? (v == 5'h1F ? v : v + 5'h01) : (v == 5'h00 ? v : v - 5'h01);
      return v;
   endfunction
   task automatic cmd(input int c, input logic d, input logic [4:0] n, input logic s);
      int k;
      @(negedge mclk);
      cmd_valid[c] = 1;
      cmd_dir[c] = d;
      cmd_steps[5*c+:5] = n;
      cmd_store[c] = s;
      for (k = 0; k < 50 && cmd_ready[c] !== 1; k++) @(negedge mclk);
      @(negedge mclk);
      cmd_valid[c] = 0;
      for (k = 0; k < 900 && cmd_ready[c] !== 1; k++) @(negedge mclk);
      ex[c] = mv(ex[c], d, n);
      hp[c] = mv(hp[c], d, n);
      if (s) sv[c] = ex[c];
      `CHK(cmd_ready[c], 1'b1)
      `CHK(pos[5*c+:5], hp[c])
      `CHK(cnt[5*c+:5], ex[c])
      `CHK(nv[5*c+:5], sv[c])
   endtask
   task sc_up_store;
      cmd(0, 1, 5'h03, 1);
      `CHK(cnt[9:5], ex[1])
   endtask
   task sc_down_skip;
      cmd(0, 0, 5'h02, 0);
      cmd(0, 0, 5'h00, 0);
      cmd(0, 1, 5'h00, 1);
   endtask
   task sc_sat;
      cmd(0, 1, 5'h1F, 0);
      cmd(0, 0, 5'h1F, 1);
   endtask
   task sc_dual;
      fork
         cmd(0, 1, 5'h01, 0);
         cmd(1, 1, 5'h04, 1);
      join
   endtask
   task complete_run;
      $display("errors %0d checks %0d", num_errors, total_checks);
      if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge mclk);
      rst = 0;
      sc_up_store();
      sc_down_skip();
      sc_sat();
      sc_dual();
      complete_run();
   end
endmodule // test_wiper_host

//--- test/wiper_dev.sv
`timescale 1ns/100ps
// ====
// device: counter and stored copy per channel
module wiper_dev #(
   parameter [9:0] RECALL = 10'h0A5
) (
   // pins
   input  wire [1:0] sel_n,
   input  wire [1:0] step_n,
   input  wire [1:0] dir,
   // state
   output reg  [9:0] cnt,
   output reg  [9:0] nv
);
   wire [31:0] tap0 = 32'h1 << cnt[4:0];
   initial begin
      nv = RECALL;
      cnt = nv;
   end
   for (genvar c = 0; c < 2; c++) begin : g_ch
      always @(negedge step_n[c]) if (!sel_n[c])
         cnt[5*c+:5] <= dir[c] ? (&cnt[5*c+:5] ? 5'h1F : cnt[5*c+:5] + 5'h01)
                               : (|cnt[5*c+:5] ? cnt[5*c+:5] - 5'h01 : 5'h00);
      always @(posedge sel_n[c]) if (step_n[c]) nv[5*c+:5] <= cnt[5*c+:5];
   end
endmodule // wiper_dev

//--- test/wiper_host_chk.sv
`timescale 1ns/100ps
// ====
// pin checks, channel 0, plus both selects after reset
module wiper_host_chk (
   input wire       mclk,
   input wire       rst,
   input wire [1:0] cmd_valid,
   input wire [1:0] cmd_ready,
   input wire [9:0] cmd_steps,
   input wire [1:0] cmd_store,
   input wire [9:0] pos,
   input wire [1:0] sel_n,
   input wire [1:0] step_n,
   input wire [1:0] dir
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_sel_after_rst: assert property ($past(rst) |-> sel_n == 2'h3) else $error("sel low");
   a_take_selects: assert property (cmd_valid[0] && cmd_ready[0]
      && (cmd_steps[4:0] != 5'h00 || cmd_store[0]) |=> !cmd_ready[0] && !sel_n[0]) else $error("take");
   a_step_needs_sel: assert property ($fell(step_n[0]) |-> !sel_n[0]) else $error("step idle");
   a_step_low_len: assert property ($fell(step_n[0]) |-> !step_n[0] [*8]) else $error("short");
   a_dir_steady: assert property (!step_n[0] |-> $stable(dir[0])) else $error("dir moved");
   a_rise_steady: assert property ($rose(sel_n[0]) |->
      $stable(step_n[0]) && $past(step_n[0], 2) == step_n[0]) else $error("step at rise");
   a_store_hold: assert property ($rose(sel_n[0]) && step_n[0] |->
      sel_n[0] [*8] ##1 !cmd_ready[0]) else $error("reselect");
   a_pos_up: assert property ($fell(step_n[0]) && dir[0] |-> pos[4:0] ==
      ($past(pos[4:0]) == 5'h1F ? 5'h1F : $past(pos[4:0]) + 5'h01)) else $error("pos");
   c_store: cover property ($rose(sel_n[0]) && step_n[0]);
   c_skip: cover property ($rose(sel_n[0]) && !step_n[0]);
   c_top: cover property (pos[4:0] == 5'h1F);
endmodule // wiper_host_chk
bind wiper_host wiper_host_chk u_wiper_host_chk (.mclk, .rst, .cmd_valid, .cmd_ready, .cmd_steps, .cmd_store,
   .pos, .sel_n, .step_n, .dir);
